/* profile_consts.vh */
`ifndef PROFILE_CONSTS_VH
`define PROFILE_CONSTS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define TICK_NS 100000000
`define SEC_NS 1000000000
`define TICKS_PER_SEC (`SEC_NS / `TICK_NS)
`define SEC_PER_MIN 60
`define SEC_PER_HOUR 3600

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define A_CTRL 12'h000
`define A_IDLE 12'h004
`define A_LOOPCNT 12'h008
`define A_RESTART 12'h00C
`define A_NSECT 12'h010
`define A_SRCSEL 12'h014
`define A_MONTHS 12'h018
`define A_DAYS 12'h01C
`define A_WDAYS 12'h020
`define A_HOURS 12'h024
`define A_MIN_LO 12'h028
`define A_MIN_HI 12'h02C
`define A_SEC_LO 12'h030
`define A_SEC_HI 12'h034
`define A_STATUS 12'h038
`define A_OUTVAL 12'h03C
`define SECT_BASE_BIT 11
`define F_DUR 2'h0
`define F_FINAL 2'h1
`define F_SHAPE 2'h2

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define TRIG_OFF 3'h0
`define TRIG_GATE 3'h1
`define TRIG_ONCE 3'h2
`define TRIG_RETRIG 3'h3
`define TRIG_TIME 3'h4
`define LOOP_OFF 2'h0
`define LOOP_COUNT 2'h1
`define LOOP_CHAN 2'h2
`define LOOP_INF 2'h3
`define UNIT_SEC 2'h0
`define UNIT_MIN 2'h1
`define UNIT_HOUR 2'h2
`define MAX_SECTIONS 100
`define NSECT_LIMIT 7'h64

`endif

/* section_profile_generator.v */
`timescale 1ns/1ps
`include "profile_consts.vh"

module section_profile_generator
#(
    parameter VW = 16,
    parameter N_CH = 16,
    parameter CH_W = 4,
    parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
)
(
    input wire mclk,
    input wire arst_n,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata_q,
    input wire [N_CH*VW-1:0] chan_vals,
    input wire [3:0] cal_month,
    input wire [4:0] cal_day,
    input wire [2:0] cal_wday,
    input wire [4:0] cal_hour,
    input wire [5:0] cal_min,
    input wire [5:0] cal_sec,
    output reg [VW-1:0] out_value_q,
    output reg running_q
);

// ----------------------------------------------------------------------
// functions
// ----------------------------------------------------------------------
function [31:0] dur_ticks;
    input [15:0] dur;
    input [1:0] unit;
    reg [31:0] secs;
    begin
        case (unit)
            `UNIT_MIN: secs = {16'h0000, dur} * `SEC_PER_MIN;
            `UNIT_HOUR: secs = {16'h0000, dur} * `SEC_PER_HOUR;
            default: secs = {16'h0000, dur};
        endcase
        dur_ticks = secs * `TICKS_PER_SEC;
        if (dur_ticks == 32'h0000_0000)
            dur_ticks = 32'h0000_0001;
    end
endfunction

function [VW-1:0] interp;
    input [VW-1:0] a;
    input [VW-1:0] b;
    input [31:0] n;
    input [31:0] d;
    reg signed [VW+33:0] p;
    reg signed [VW+33:0] q;
    begin
        p = ($signed({b[VW-1], b}) - $signed({a[VW-1], a}))
            * $signed({1'b0, n});
        q = p / $signed({1'b0, d});
        interp = a + q[VW-1:0];
    end
endfunction

function [VW-1:0] chan_pick;
    input [N_CH*VW-1:0] all;
    input [CH_W-1:0] sel;
    begin
        chan_pick = all[sel*VW +: VW];
    end
endfunction

// ----------------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------------
reg [2:0] trig_mode_q;
reg [1:0] loop_mode_q;
reg [VW-1:0] idle_q;
reg [15:0] loop_count_q;
reg [6:0] restart_section_select_q;
reg [6:0] nsect_q;
reg [CH_W-1:0] trig_sel_q;
reg [CH_W-1:0] loop_sel_q;
reg [11:0] months_q;
reg [30:0] days_q;
reg [6:0] wdays_q;
reg [23:0] hours_q;
reg [59:0] mins_q;
reg [59:0] secs_q;
// section table, one entry per section
reg [15:0] sect_dur [0:`MAX_SECTIONS-1];
reg [VW-1:0] sect_final [0:`MAX_SECTIONS-1];
reg [1:0] sect_unit [0:`MAX_SECTIONS-1];
reg sect_slope [0:`MAX_SECTIONS-1];

wire sect_hit = addr[`SECT_BASE_BIT];
wire [6:0] sect_idx = addr[10:4];
wire [1:0] sect_fld = addr[3:2];
wire sect_ok = sect_hit && (sect_idx < `MAX_SECTIONS);

// ----------------------------------------------------------------------
// sequencer state
// ----------------------------------------------------------------------
localparam S_IDLE = 1'b0;
localparam S_RUN = 1'b1;

reg state_q;
reg [6:0] cur_q;
reg [31:0] elapsed_q;
reg [VW-1:0] prev_q;
reg [15:0] cycles_q;
reg prev_pos_q;
reg [5:0] prev_sec_q;
reg gate_done_q;
reg [31:0] tick_cnt_q;
reg tick_q;

// tick divider: one enable pulse per tick; seconds, minutes and hours are counted in ticks
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        tick_cnt_q <= 32'h0000_0000;
        tick_q <= 1'b0;
    end
    else if (tick_cnt_q == TICK_CYCLES - 1)
    begin
        tick_cnt_q <= 32'h0000_0000;
        tick_q <= 1'b1;
    end
    else
    begin
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        tick_q <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// trigger decode
// ----------------------------------------------------------------------
wire [VW-1:0] trig_val = chan_pick(chan_vals, trig_sel_q);
wire [VW-1:0] loop_val = chan_pick(chan_vals, loop_sel_q);
wire src_pos = !trig_val[VW-1] && (trig_val != {VW{1'b0}});
wire rise = src_pos && !prev_pos_q;

wire fields_set = (months_q != 12'h000) && (days_q != 31'h0000_0000)
    && (wdays_q != 7'h00) && (hours_q != 24'h00_0000)
    && (mins_q != 60'h0) && (secs_q != 60'h0);
wire cal_match = fields_set
    && (cal_month != 4'h0) && months_q[cal_month - 4'h1]
    && (cal_day != 5'h00) && days_q[cal_day - 5'h01]
    && wdays_q[cal_wday] && hours_q[cal_hour]
    && mins_q[cal_min] && secs_q[cal_sec];
// one match per second keeps the one-second resolution
wire new_sec = (cal_sec != prev_sec_q);

reg start;
reg stop;
always @*
begin
    start = 1'b0;
    stop = 1'b0;
    case (trig_mode_q)
        `TRIG_GATE:
        begin
            start = src_pos && (state_q == S_IDLE) && !gate_done_q;
            stop = !src_pos && (state_q == S_RUN);
        end
        `TRIG_ONCE: start = rise && (state_q == S_IDLE);
        `TRIG_RETRIG: start = rise;
        `TRIG_TIME:
            start = cal_match && new_sec && (state_q == S_IDLE);
        default:
        begin
            start = 1'b0;
            stop = (state_q == S_RUN);
        end
    endcase
    if (nsect_q == 7'h00)
        start = 1'b0;
end

// ----------------------------------------------------------------------
// current section
// ----------------------------------------------------------------------
wire [31:0] cur_len = dur_ticks(sect_dur[cur_q], sect_unit[cur_q]);
wire [VW-1:0] cur_final = sect_final[cur_q];
wire cur_slope = sect_slope[cur_q];
wire [31:0] el_next = elapsed_q + 32'h0000_0001;
wire sect_end = (el_next >= cur_len);
wire last_sect = (cur_q + 7'h01 >= nsect_q);
wire [15:0] cyc_next = cycles_q + 16'h0001;

reg again;
always @*
begin
    case (loop_mode_q)
        `LOOP_COUNT: again = (cyc_next < loop_count_q);
        `LOOP_CHAN: again = ($signed({1'b0, cyc_next})
            < $signed(loop_val));
        `LOOP_INF: again = 1'b1;
        default: again = 1'b0;
    endcase
end

// restart position beyond the list falls back to the first section
wire [6:0] ret_sect = (restart_section_select_q < nsect_q) ?
    restart_section_select_q : 7'h00;

// ----------------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------------
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state_q <= S_IDLE;
        cur_q <= 7'h00;
        elapsed_q <= 32'h0000_0000;
        prev_q <= {VW{1'b0}};
        cycles_q <= 16'h0000;
        prev_pos_q <= 1'b0;
        prev_sec_q <= 6'h00;
        gate_done_q <= 1'b0;
        out_value_q <= {VW{1'b0}};
        running_q <= 1'b0;
    end
    else
    begin
        prev_pos_q <= src_pos;
        prev_sec_q <= cal_sec;
        if (!src_pos)
            gate_done_q <= 1'b0;
        if (start)
        begin
            state_q <= S_RUN;
            running_q <= 1'b1;
            cur_q <= 7'h00;
            elapsed_q <= 32'h0000_0000;
            prev_q <= idle_q;
            cycles_q <= 16'h0000;
        end
        else if (stop)
        begin
            state_q <= S_IDLE;
            running_q <= 1'b0;
            out_value_q <= idle_q;
        end
        else if (state_q == S_IDLE)
            out_value_q <= idle_q;
        else if (tick_q)
        begin
            if (cur_slope)
                out_value_q <= interp(prev_q, cur_final, el_next,
                    cur_len);
            else
                out_value_q <= cur_final;
            if (!sect_end)
                elapsed_q <= el_next;
            else
            begin
                elapsed_q <= 32'h0000_0000;
                prev_q <= cur_final;
                if (!last_sect)
                    cur_q <= cur_q + 7'h01;
                else
                begin
                    cycles_q <= cyc_next;
                    if (again)
                        cur_q <= ret_sect;
                    else
                    begin
                        state_q <= S_IDLE;
                        running_q <= 1'b0;
                        gate_done_q <= (trig_mode_q == `TRIG_GATE);
                    end
                end
            end
        end
    end
end

// ----------------------------------------------------------------------
// register writes
// ----------------------------------------------------------------------
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        trig_mode_q <= `TRIG_OFF;
        loop_mode_q <= `LOOP_OFF;
        idle_q <= {VW{1'b0}};
        loop_count_q <= 16'h0000;
        restart_section_select_q <= 7'h00;
        nsect_q <= 7'h00;
        trig_sel_q <= {CH_W{1'b0}};
        loop_sel_q <= {CH_W{1'b0}};
        months_q <= 12'h000;
        days_q <= 31'h0000_0000;
        wdays_q <= 7'h00;
        hours_q <= 24'h00_0000;
        mins_q <= 60'h0;
        secs_q <= 60'h0;
    end
    else if (wr_stb && !sect_hit)
    begin
        case (addr)
            `A_CTRL:
            begin
                trig_mode_q <= wdata[2:0];
                loop_mode_q <= wdata[5:4];
            end
            `A_IDLE: idle_q <= wdata[VW-1:0];
            `A_LOOPCNT: loop_count_q <= wdata[15:0];
            `A_RESTART: restart_section_select_q <= wdata[6:0];
            `A_NSECT: nsect_q <= (wdata[6:0] > `NSECT_LIMIT) ?
                `NSECT_LIMIT : wdata[6:0];
            `A_SRCSEL:
            begin
                trig_sel_q <= wdata[CH_W-1:0];
                loop_sel_q <= wdata[8 +: CH_W];
            end
            `A_MONTHS: months_q <= wdata[11:0];
            `A_DAYS: days_q <= wdata[30:0];
            `A_WDAYS: wdays_q <= wdata[6:0];
            `A_HOURS: hours_q <= wdata[23:0];
            `A_MIN_LO: mins_q[31:0] <= wdata;
            `A_MIN_HI: mins_q[59:32] <= wdata[27:0];
            `A_SEC_LO: secs_q[31:0] <= wdata;
            `A_SEC_HI: secs_q[59:32] <= wdata[27:0];
            default: ;
        endcase
    end
end

// table memory has no reset: software loads it before enabling
always @(posedge mclk)
begin
    if (wr_stb && sect_ok)
    begin
        case (sect_fld)
            `F_DUR: sect_dur[sect_idx] <= wdata[15:0];
            `F_FINAL: sect_final[sect_idx] <= wdata[VW-1:0];
            `F_SHAPE:
            begin
                sect_unit[sect_idx] <= wdata[1:0];
                sect_slope[sect_idx] <= wdata[4];
            end
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------------
// register reads
// ----------------------------------------------------------------------
reg [31:0] rd_mux;
always @*
begin
    rd_mux = 32'h0000_0000;
    if (sect_ok)
    begin
        case (sect_fld)
            `F_DUR: rd_mux = {16'h0000, sect_dur[sect_idx]};
            `F_FINAL: rd_mux[VW-1:0] = sect_final[sect_idx];
            `F_SHAPE: rd_mux = {27'h0, sect_slope[sect_idx], 2'h0,
                sect_unit[sect_idx]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    else if (!sect_hit)
    begin
        case (addr)
            `A_CTRL: rd_mux = {26'h0, loop_mode_q, 1'b0, trig_mode_q};
            `A_IDLE: rd_mux[VW-1:0] = idle_q;
            `A_LOOPCNT: rd_mux = {16'h0000, loop_count_q};
            `A_RESTART: rd_mux = {25'h0, restart_section_select_q};
            `A_NSECT: rd_mux = {25'h0, nsect_q};
            `A_SRCSEL:
            begin
                rd_mux[CH_W-1:0] = trig_sel_q;
                rd_mux[8 +: CH_W] = loop_sel_q;
            end
            `A_MONTHS: rd_mux = {20'h0, months_q};
            `A_DAYS: rd_mux = {1'b0, days_q};
            `A_WDAYS: rd_mux = {25'h0, wdays_q};
            `A_HOURS: rd_mux = {8'h00, hours_q};
            `A_MIN_LO: rd_mux = mins_q[31:0];
            `A_MIN_HI: rd_mux = {4'h0, mins_q[59:32]};
            `A_SEC_LO: rd_mux = secs_q[31:0];
            `A_SEC_HI: rd_mux = {4'h0, secs_q[59:32]};
            `A_STATUS: rd_mux = {cycles_q, 1'b0, cur_q, 7'h00, running_q};
            `A_OUTVAL: rd_mux[VW-1:0] = out_value_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
end

// read data valid in the cycle after the strobe only
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
        rdata_q <= 32'h0000_0000;
    else if (rd_stb)
        rdata_q <= rd_mux;
    else
        rdata_q <= 32'h0000_0000;
end

endmodule

/* section_profile_generator_asserts.sv */
`timescale 1ns/1ps
`include "profile_consts.vh"
module section_profile_generator_asserts
#(
    parameter VW = 16,
    parameter N_CH = 16
)
(
    input wire mclk,
    input wire arst_n,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire [N_CH*VW-1:0] chan_vals,
    input wire [VW-1:0] out_value_q,
    input wire running_q
);
    // ------
    // shadow of the configuration
    // ------
    logic [2:0] mode_q;
    logic [3:0] src_q;
    logic [VW-1:0] idle_q;
    logic [1:0] low_q;
    logic pos;
    assign pos = $signed(chan_vals[src_q*VW +: VW]) > 0;
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_q <= 3'h0;
            src_q <= 4'h0;
            idle_q <= '0;
            low_q <= 2'h0;
        end
        else
        begin
            if (wr_stb && addr == `A_CTRL)
                mode_q <= wdata[2:0];
            if (wr_stb && addr == `A_SRCSEL)
                src_q <= wdata[3:0];
            if (wr_stb && addr == `A_IDLE)
                idle_q <= wdata[VW-1:0];
            // saturates so a long low spell never wraps to zero
            if (pos)
                low_q <= 2'h0;
            else if (low_q != 2'h3)
                low_q <= low_q + 2'h1;
        end
    end
    // ------
    // properties
    // ------
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_off_idle;
        mode_q == `TRIG_OFF && $past(mode_q) == `TRIG_OFF |-> !running_q;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("running while disabled");
    property p_idle_out;
        !running_q && !$past(running_q) && idle_q == $past(idle_q)
            |-> out_value_q == idle_q;
    endproperty
    a_idle_out: assert property (p_idle_out)
        else $error("output not idle value");
    property p_gate_stop;
        mode_q == `TRIG_GATE && $past(mode_q) == `TRIG_GATE && low_q == 2'h3
            |-> !running_q;
    endproperty
    a_gate_stop: assert property (p_gate_stop)
        else $error("gate low but running");
    property p_gate_start;
        mode_q == `TRIG_GATE && $past(mode_q) == `TRIG_GATE && pos
            && !$past(pos) && !running_q |=> running_q;
    endproperty
    a_gate_start: assert property (p_gate_start)
        else $error("gate high but not running");
    property p_once_start;
        mode_q == `TRIG_ONCE && $past(mode_q) == `TRIG_ONCE && pos
            && !$past(pos) && !running_q |=> running_q;
    endproperty
    a_once_start: assert property (p_once_start)
        else $error("edge did not start");
    property p_once_edge;
        mode_q == `TRIG_ONCE && $past(mode_q) == `TRIG_ONCE
            && $rose(running_q) |-> $past(pos) && !$past(pos, 2);
    endproperty
    a_once_edge: assert property (p_once_edge)
        else $error("start without edge");
    property p_retrig;
        mode_q == `TRIG_RETRIG && $past(mode_q) == `TRIG_RETRIG && pos
            && !$past(pos) |=> running_q;
    endproperty
    a_retrig: assert property (p_retrig)
        else $error("retrigger edge lost");
    // retrigger restarts the sequence on each rising edge, so it is left out here
    property p_tick_hold;
        mode_q != `TRIG_RETRIG && running_q && $past(running_q)
            && $changed(out_value_q)
            |=> (!running_q || $stable(out_value_q)) [*8];
    endproperty
    a_tick_hold: assert property (p_tick_hold)
        else $error("output changed between ticks");
endmodule

bind section_profile_generator section_profile_generator_asserts
    #(.VW(VW), .N_CH(N_CH)) u_section_profile_generator_asserts (
    .mclk(mclk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .chan_vals(chan_vals),
    .out_value_q(out_value_q),
    .running_q(running_q)
);

/* logical_chan_model.sv */
`timescale 1ns/1ps
module logical_chan_model
#(
    parameter VW = 16,
    parameter N_CH = 16
)
(
    input wire mclk,
    input wire [VW-1:0] trig_val,
    input wire [VW-1:0] loop_val,
    output logic [N_CH*VW-1:0] chan_vals
);
    logic [VW-1:0] noise_q;
    initial
    begin
        noise_q = 16'h0001;
        chan_vals = '0;
    end
    // unused channels flip sign each cycle: a wrong select shows edges
    always @(posedge mclk)
    begin
        noise_q <= noise_q ^ 16'h8001;
        for (int k = 0; k < N_CH; k++)
            chan_vals[k*VW +: VW] <= noise_q;
        chan_vals[3*VW +: VW] <= trig_val;
        chan_vals[5*VW +: VW] <= loop_val;
    end
endmodule

/* section_profile_generator_tb_top.sv */
`timescale 1ns/1ps
`include "profile_consts.vh"
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("Error at %0t: got %0h exp %0h", $time, got, exp); \
        end \
    end
module section_profile_generator_tb_top;
    localparam VW = 16;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata_q;
    logic [16*VW-1:0] chan_vals;
    logic [3:0] cal_month = 4'h6;
    logic [4:0] cal_day = 5'h04;
    logic [2:0] cal_wday = 3'h4;
    logic [4:0] cal_hour = 5'h0E;
    logic [5:0] cal_min = 6'h2A;
    logic [5:0] cal_sec = 6'h14;
    logic [VW-1:0] out_value_q;
    logic running_q;
    logic [VW-1:0] trig = 16'h0000;
    logic [VW-1:0] lpv = 16'h0000;
    int fails = 0;
    int checked = 0;
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    logical_chan_model u_logical_chan_model (
        .mclk(mclk),
        .trig_val(trig),
        .loop_val(lpv),
        .chan_vals(chan_vals)
    );
    section_profile_generator #(.TICK_CYCLES(10)) u_section_profile_generator (
        .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
        .chan_vals(chan_vals), .cal_month(cal_month), .cal_day(cal_day),
        .cal_wday(cal_wday), .cal_hour(cal_hour), .cal_min(cal_min),
        .cal_sec(cal_sec), .out_value_q(out_value_q), .running_q(running_q)
    );
    // ------
    // bus and check tasks
    // ------
    task automatic conclude;
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input [11:0] a, input [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        `CHK(rdata_q, e)
    endtask
    task automatic sect(input [6:0] i, input [15:0] d, input [15:0] f,
                        input [31:0] s);
        wr({1'b1, i, `F_DUR, 2'h0}, {16'h0000, d});
        wr({1'b1, i, `F_FINAL, 2'h0}, {16'h0000, f});
        wr({1'b1, i, `F_SHAPE, 2'h0}, s);
    endtask
    // waits for a change (chg) or for the value itself, always bounded
    task automatic see(input [VW-1:0] e, input bit chg);
        logic [VW-1:0] v;
        int n;
        #1;
        v = out_value_q;
        n = 0;
        while ((chg ? out_value_q === v : out_value_q !== e) && n < 400)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 400)
        begin
            $display("Error at %0t: timeout got %0h exp %0h", $time,
                out_value_q, e);
            fails++;
            conclude();
        end
        else
            `CHK(out_value_q, e)
    endtask
    task automatic ramp(input int p, input int f);
        for (int k = 1; k <= 10; k++)
            see(VW'(p + (f - p) * k / 10), 1'b1);
    endtask
    task automatic pulse;
        trig <= 16'h0000;
        repeat (3) @(posedge mclk);
        trig <= 16'h0001;
    endtask
    // wig drops and re-raises the source while running; it must not matter
    task automatic profile(input int runs, input bit wig);
        ramp(5, 105);
        if (wig)
            trig <= 16'h0000;
        see(16'h004D, 1'b1);
        if (wig)
            trig <= 16'h0001;
        see(16'h0028, 1'b1);
        repeat (runs - 1)
        begin
            see(16'h004D, 1'b1);
            see(16'h0028, 1'b1);
        end
        see(16'h0005, 1'b1);
        `CHK(running_q, 1'b0)
    endtask
    // ------
    // scenarios
    // ------
    initial
    begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`A_CTRL, 32'h0000_0000);
        rd(`A_OUTVAL, 32'h0000_0000);
        rd(12'h7FC, 32'h0000_0000);
        wr(12'hE44, 32'h0000_1234);
        rd(12'hE44, 32'h0000_0000);
        wr(`A_IDLE, 32'h0000_0005);
        sect(7'h00, 16'h0001, 16'h0069, 32'h0000_0010);
        rd({1'b1, 7'h00, `F_SHAPE, 2'h0}, 32'h0000_0010);
        wr({1'b1, 7'h03, `F_SHAPE, 2'h0}, 32'h0000_0001);
        rd({1'b1, 7'h03, `F_SHAPE, 2'h0}, 32'h0000_0001);
        sect(7'h01, 16'h0000, 16'h004D, 32'h0000_0000);
        sect(7'h02, 16'h0000, 16'h0028, 32'h0000_0000);
        wr(`A_NSECT, 32'h0000_0003);
        wr(`A_RESTART, 32'h0000_0001);
        wr(`A_SRCSEL, 32'h0000_0503);
        wr(`A_LOOPCNT, 32'h0000_0002);
        rd(`A_OUTVAL, 32'h0000_0005);
        wr(`A_CTRL, 32'h0000_0012);
        trig <= 16'h0001;
        profile(2, 1'b1);
        lpv <= 16'h0003;
        wr(`A_CTRL, 32'h0000_0022);
        pulse();
        profile(3, 1'b1);
        trig <= 16'h0000;
        wr(`A_CTRL, 32'h0000_0001);
        repeat (40) @(posedge mclk);
        #1;
        `CHK(running_q, 1'b0)
        trig <= 16'h0001;
        see(16'h000F, 1'b1);
        trig <= 16'hFFFF;
        see(16'h0005, 1'b1);
        `CHK(running_q, 1'b0)
        wr(`A_RESTART, 32'h0000_0000);
        wr(`A_CTRL, 32'h0000_0033);
        trig <= 16'h0001;
        ramp(5, 105);
        see(16'h004D, 1'b1);
        pulse();
        repeat (3) @(posedge mclk);
        rd(`A_STATUS, 32'h0000_0001);
        see(16'h0028, 1'b0);
        ramp(40, 105);
        see(16'h004D, 1'b1);
        see(16'h0028, 1'b1);
        ramp(40, 105);
        wr(`A_CTRL, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(running_q, 1'b0)
        `CHK(out_value_q, 16'h0005)
        wr(`A_MONTHS, 32'h0000_0020);
        wr(`A_DAYS, 32'h0000_0008);
        wr(`A_WDAYS, 32'h0000_0010);
        wr(`A_HOURS, 32'h0000_4000);
        wr(`A_MIN_HI, 32'h0000_0400);
        wr(`A_CTRL, 32'h0000_0004);
        repeat (40) @(posedge mclk);
        #1;
        `CHK(running_q, 1'b0)
        cal_hour <= 5'h0D;
        wr(`A_SEC_LO, 32'h0010_0000);
        repeat (40) @(posedge mclk);
        #1;
        `CHK(running_q, 1'b0)
        cal_hour <= 5'h0E;
        cal_sec <= 6'h13;
        repeat (3) @(posedge mclk);
        cal_sec <= 6'h14;
        profile(1, 1'b0);
        repeat (40) @(posedge mclk);
        #1;
        `CHK(running_q, 1'b0)
        conclude();
    end
endmodule
